//--- rtl/rbs_pkg.sv
package rbs_pkg;

  localparam int RBS_DEPTH       = 2500;
  localparam int RBS_CAP_MIN     = 2;
  localparam int RBS_CAP_DEFAULT = 100;
  localparam int RBS_MAX_FIELDS  = 10;
  localparam int RBS_DEF_FIELDS  = 4;
  localparam int RBS_CHANNEL_ONE = 1;
  localparam int RBS_IDX_W       = 12;
  localparam int RBS_CHAN_W      = 4;
  localparam int RBS_FCNT_W      = 4;
  localparam logic RBS_AUTOCLEAR_RESET = 1'b1;

  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int DAY_HOURS     = 24;
  localparam int DAY_TICKS     = DAY_HOURS * 3600 * (1000000000 / TICK_NS);

  typedef enum logic [3:0] {
    reading_field,
    source_field,
    unit_field,
    output_state_field,
    date_field,
    time_field,
    absolute_stamp_field,
    relative_seconds_field,
    relative_stamp_field,
    point_index_field
  } rbs_field_t;

  typedef rbs_field_t [RBS_MAX_FIELDS-1:0] rbs_flist_t;

  typedef enum logic [1:0] {
    fill_once,
    fill_continuous,
    fill_never
  } rbs_fill_t;

  typedef enum logic [1:0] {
    output_off_state,
    constant_current_state,
    constant_voltage_state
  } rbs_ostate_t;

  typedef enum logic [1:0] {
    unit_volts,
    unit_amps
  } rbs_unit_t;

  typedef struct packed {
    logic [31:0] reading;
    logic [31:0] source;
    rbs_unit_t   unit;
    rbs_ostate_t ostate;
  } rbs_sample_t;

  typedef struct packed {
    logic [31:0] date;
    logic [31:0] tod;
  } rbs_rtc_t;

  typedef struct packed {
    rbs_sample_t smp;
    rbs_rtc_t    rtc;
    logic [31:0] rel;
  } rbs_rec_t;

  typedef struct packed {
    rbs_field_t             field;
    logic [RBS_IDX_W-1:0]   index;
    logic [63:0]            data;
    logic                   last;
  } rbs_word_t;

endpackage

//--- rtl/rbs_store.sv
`timescale 1ns/1ps
`default_nettype none

module rbs_store
  import rbs_pkg::*;
#(
  parameter int DEPTH       = RBS_DEPTH,
  parameter int TICK_CYC    = TICK_CYCLES,
  parameter int DAY_TICK    = DAY_TICKS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clear_cmd,
  input  wire logic                  autoclear_wr,
  input  wire logic                  autoclear_val,
  output logic                       autoclear_q,
  input  wire rbs_fill_t             fill_mode,
  input  wire logic [RBS_IDX_W-1:0]  capacity,
  input  wire logic                  run_start,
  input  wire logic                  run_stop,
  input  wire logic                  sample_valid,
  input  wire rbs_sample_t           sample,
  input  wire rbs_rtc_t              rtc,
  input  wire logic [RBS_CHAN_W-1:0] channel,
  input  wire logic                  readall_req,
  input  wire logic                  range_req,
  input  wire logic [RBS_IDX_W-1:0]  range_start,
  input  wire logic [RBS_IDX_W-1:0]  range_end,
  input  wire logic [RBS_FCNT_W-1:0] field_count,
  input  wire rbs_flist_t            fields,
  output logic                       busy,
  output logic                       cmd_error,
  output logic                       reply_done,
  output logic                       storing,
  output logic [RBS_IDX_W-1:0]       stored_count,
  output rbs_word_t                  word,
  output logic                       word_valid,
  input  wire logic                  word_ready
);

  if (DEPTH < RBS_CAP_MIN || DEPTH >= (1 << RBS_IDX_W) || TICK_CYC < 1 || DAY_TICK < 2) begin
    $error("rbs_store: unsupported parameter values");
  end

  typedef enum {Q_IDLE, Q_READ, Q_WAIT, Q_EMIT} rbs_qstate_t;

  localparam logic [RBS_IDX_W-1:0] IDX_ONE  = RBS_IDX_W'(1);
  localparam logic [RBS_IDX_W-1:0] IDX_MAX  = RBS_IDX_W'(RBS_DEPTH);
  localparam logic [RBS_IDX_W-1:0] CAP_LO   = RBS_IDX_W'(RBS_CAP_MIN);
  localparam logic [RBS_IDX_W-1:0] CAP_HI   = RBS_IDX_W'(DEPTH);
  localparam logic [RBS_IDX_W-1:0] CAP_DEF  = RBS_IDX_W'(RBS_CAP_DEFAULT);
  localparam logic [31:0]          TICK_END = 32'(TICK_CYC - 1);
  localparam logic [31:0]          DAY_END  = 32'(DAY_TICK - 1);

  rbs_rec_t mem [DEPTH];
  rbs_rec_t mem_q;

  logic                  acl_r;
  logic [RBS_IDX_W-1:0]  cap_r;
  logic [RBS_IDX_W-1:0]  head_r;
  logic [RBS_IDX_W-1:0]  count_r;
  logic                  storing_r;
  logic                  filled_r;
  logic [RBS_IDX_W-1:0]  rd_done_r;
  logic                  rel_run_r;
  logic [31:0]           tick_r;
  logic [31:0]           rel_r;
  rbs_qstate_t           q_r;
  logic [RBS_IDX_W-1:0]  cur_r;
  logic [RBS_IDX_W-1:0]  last_r;
  logic [RBS_FCNT_W-1:0] fi_r;
  logic [RBS_FCNT_W-1:0] nf_r;
  rbs_flist_t            flist_r;
  rbs_word_t             word_r;
  logic                  word_valid_r;
  logic                  err_r;
  logic                  done_r;
  logic                  busy_r;

  // offset (0-based) from head to a physical slot of the ring
  function automatic logic [RBS_IDX_W-1:0] slot(input logic [RBS_IDX_W-1:0] base,
                                                input logic [RBS_IDX_W-1:0] off,
                                                input logic [RBS_IDX_W-1:0] cap);
    logic [RBS_IDX_W:0] s;
    s = {1'b0, base} + {1'b0, off};
    if (s >= {1'b0, cap}) begin
      s = s - {1'b0, cap};
    end
    return s[RBS_IDX_W-1:0];
  endfunction

  function automatic logic [63:0] field_val(input rbs_rec_t r, input rbs_field_t f,
                                            input logic [RBS_IDX_W-1:0] idx);
    case (f)
      reading_field:          return {32'h0, r.smp.reading};
      source_field:           return {32'h0, r.smp.source};
      unit_field:             return {62'h0, r.smp.unit};
      output_state_field:     return {62'h0, r.smp.ostate};
      date_field:             return {32'h0, r.rtc.date};
      time_field:             return {32'h0, r.rtc.tod};
      absolute_stamp_field:   return {r.rtc.date, r.rtc.tod};
      relative_seconds_field: return {32'h0, r.rel};
      relative_stamp_field:   return {32'h0, r.rel};
      point_index_field:      return {{(64-RBS_IDX_W){1'b0}}, idx};
      default:                return 64'h0;
    endcase
  endfunction

  logic                 clr;
  logic                 full;
  logic                 do_store;
  logic [RBS_IDX_W-1:0] cap_in;
  logic [RBS_IDX_W-1:0] wr_addr;
  logic [RBS_IDX_W-1:0] rd_addr;
  logic                 first_store;

  assign clr         = clear_cmd || (run_start && acl_r);
  assign full        = (count_r == cap_r);
  // a full fill-once buffer takes no more readings
  assign do_store    = sample_valid && storing_r && !(full && fill_mode == fill_once);
  assign first_store = do_store && !rel_run_r;
  assign cap_in      = (capacity < CAP_LO) ? CAP_LO : (capacity > CAP_HI) ? CAP_HI : capacity;
  assign wr_addr     = full ? head_r : slot(head_r, count_r, cap_r);
  assign rd_addr     = slot(head_r, cur_r - IDX_ONE, cap_r);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acl_r <= RBS_AUTOCLEAR_RESET;
    end else if (autoclear_wr) begin
      acl_r <= autoclear_val;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r     <= CAP_DEF;
      head_r    <= '0;
      count_r   <= '0;
      filled_r  <= 1'b0;
      storing_r <= 1'b0;
    end else begin
      if (clr) begin
        cap_r    <= cap_in;
        head_r   <= '0;
        count_r  <= '0;
        filled_r <= 1'b0;
      end else if (do_store) begin
        if (!full) begin
          count_r <= count_r + IDX_ONE;
          if (count_r + IDX_ONE == cap_r) begin
            filled_r <= 1'b1;
          end
        end else begin
          head_r <= slot(head_r, IDX_ONE, cap_r);
        end
      end
      if (run_start) begin
        storing_r <= (fill_mode != fill_never);
      end else if (run_stop || (sample_valid && full && fill_mode == fill_once)) begin
        storing_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_store && !clr) begin
      mem[wr_addr] <= '{smp: sample, rtc: rtc, rel: first_store ? 32'h0 : rel_r};
    end
    mem_q <= mem[rd_addr];
  end

  // relative clock: origin at the first stored reading, folds back after a day
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_run_r <= 1'b0;
      tick_r    <= '0;
      rel_r     <= '0;
    end else if (clr) begin
      rel_run_r <= 1'b0;
      tick_r    <= '0;
      rel_r     <= '0;
    end else if (first_store) begin
      rel_run_r <= 1'b1;
      tick_r    <= '0;
      rel_r     <= '0;
    end else if (rel_run_r) begin
      if (tick_r == TICK_END) begin
        tick_r <= '0;
        rel_r  <= (rel_r == DAY_END) ? 32'h0 : rel_r + 32'h1;
      end else begin
        tick_r <= tick_r + 32'h1;
      end
    end
  end

  logic                  req;
  logic                  req_bad;
  logic [RBS_IDX_W-1:0]  req_first;
  logic [RBS_IDX_W-1:0]  req_last;
  rbs_flist_t            req_flist;
  logic [RBS_FCNT_W-1:0] req_nf;

  always_comb begin
    req     = readall_req || range_req;
    req_bad = (channel != RBS_CHAN_W'(RBS_CHANNEL_ONE))
           || (field_count > RBS_FCNT_W'(RBS_MAX_FIELDS))
           || (range_req && (range_start < IDX_ONE || range_start > IDX_MAX
                          || range_end < IDX_ONE || range_end > IDX_MAX));
    if (readall_req) begin
      req_first = filled_r ? IDX_ONE : rd_done_r + IDX_ONE;
      req_last  = count_r;
    end else begin
      req_first = range_start;
      req_last  = (range_end > count_r) ? count_r : range_end;
    end
    req_flist = fields;
    req_nf    = field_count;
    if (field_count == '0) begin
      req_flist    = '{default: reading_field};
      req_flist[1] = source_field;
      req_flist[2] = unit_field;
      req_flist[3] = relative_seconds_field;
      req_nf       = RBS_FCNT_W'(RBS_DEF_FIELDS);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r          <= Q_IDLE;
      rd_done_r    <= '0;
      cur_r        <= IDX_ONE;
      last_r       <= '0;
      fi_r         <= '0;
      nf_r         <= '0;
      flist_r      <= '{default: reading_field};
      word_r       <= '0;
      word_valid_r <= 1'b0;
      err_r        <= 1'b0;
      done_r       <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      err_r  <= 1'b0;
      done_r <= 1'b0;
      if (clr) begin
        q_r          <= Q_IDLE;
        rd_done_r    <= '0;
        word_valid_r <= 1'b0;
        busy_r       <= 1'b0;
      end else begin
        case (q_r)
          Q_IDLE: begin
            if (req && req_bad) begin
              err_r <= 1'b1;
            end else if (req) begin
              if (readall_req) begin
                rd_done_r <= count_r;
              end
              cur_r   <= req_first;
              last_r  <= req_last;
              flist_r <= req_flist;
              nf_r    <= req_nf;
              fi_r    <= '0;
              if (req_first > req_last) begin
                done_r <= 1'b1;
              end else begin
                q_r    <= Q_READ;
                busy_r <= 1'b1;
              end
            end
          end
          Q_READ: q_r <= Q_WAIT;
          Q_WAIT: q_r <= Q_EMIT;
          Q_EMIT: begin
            if (!word_valid_r) begin
              word_r.field <= flist_r[fi_r];
              word_r.index <= cur_r;
              word_r.data  <= field_val(mem_q, flist_r[fi_r], cur_r);
              word_r.last  <= (fi_r == nf_r - 1'b1) && (cur_r == last_r);
              word_valid_r <= 1'b1;
            end else if (word_ready) begin
              word_valid_r <= 1'b0;
              if (fi_r == nf_r - 1'b1) begin
                fi_r <= '0;
                if (cur_r == last_r) begin
                  done_r <= 1'b1;
                  busy_r <= 1'b0;
                  q_r    <= Q_IDLE;
                end else begin
                  cur_r <= cur_r + IDX_ONE;
                  q_r   <= Q_READ;
                end
              end else begin
                fi_r <= fi_r + 1'b1;
              end
            end
          end
          default: q_r <= Q_IDLE;
        endcase
      end
    end
  end

  assign autoclear_q  = acl_r;
  assign busy         = busy_r;
  assign cmd_error    = err_r;
  assign reply_done   = done_r;
  assign storing      = storing_r;
  assign stored_count = count_r;
  assign word         = word_r;
  assign word_valid   = word_valid_r;

endmodule

`default_nettype wire

//--- tb/rbs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_checker
  import rbs_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  clear_cmd,
  input wire logic                  autoclear_wr,
  input wire logic                  autoclear_val,
  input wire logic                  autoclear_q,
  input wire logic                  run_start,
  input wire logic                  sample_valid,
  input wire logic                  storing,
  input wire logic [RBS_IDX_W-1:0]  stored_count,
  input wire logic [RBS_CHAN_W-1:0] channel,
  input wire logic                  readall_req,
  input wire logic                  range_req,
  input wire logic [RBS_IDX_W-1:0]  range_start,
  input wire logic [RBS_IDX_W-1:0]  range_end,
  input wire logic [RBS_FCNT_W-1:0] field_count,
  input wire logic                  busy,
  input wire logic                  cmd_error,
  input wire logic                  reply_done,
  input wire rbs_word_t             word,
  input wire logic                  word_valid,
  input wire logic                  word_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_range_ok;
    range_req && !readall_req && !busy && channel == 4'h1 && field_count <= 4'ha
      && range_start == 12'h001 && range_end != 12'h000 && range_end <= 12'h9c4
      && stored_count != 12'h000;
  endsequence
  sequence s_handshake;
    word_valid && word_ready;
  endsequence
  a_clear_empty: assert property (clear_cmd |=> stored_count == 12'h000)
    else $error("count not zero after clear");
  a_ac_write: assert property (autoclear_wr |=> autoclear_q == $past(autoclear_val))
    else $error("auto-clear setting not taken");
  a_ac_start: assert property (run_start && autoclear_q |=> stored_count == 12'h000)
    else $error("run start did not empty buffer");
  a_store_one: assert property (storing && sample_valid && !clear_cmd && !run_start
    && stored_count == 12'h000 |=> stored_count == 12'h001) else $error("sample not appended");
  a_idle_hold: assert property (!storing && !clear_cmd && !run_start |=> $stable(stored_count))
    else $error("count moved while not storing");
  a_chan_error: assert property ((readall_req || range_req) && !busy && channel != 4'h1
    |=> cmd_error ##1 !cmd_error) else $error("bad channel not refused");
  a_first_word: assert property (s_range_ok |=> busy ##3 (word_valid && word.index == 12'h001))
    else $error("range reply not starting at index one");
  a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word))
    else $error("word dropped before ready");
  a_word_bubble: assert property (s_handshake |=> !word_valid)
    else $error("no bubble after handshake");
  a_last_done: assert property (s_handshake ##0 word.last |=> reply_done ##1 !reply_done)
    else $error("reply end not flagged");
endmodule
bind rbs_store rbs_checker u_rbs_checker (.sys_clk, .rst_n, .clear_cmd, .autoclear_wr,
  .autoclear_val, .autoclear_q, .run_start, .sample_valid, .storing, .stored_count, .channel,
  .readall_req, .range_req, .range_start, .range_end, .field_count, .busy, .cmd_error,
  .reply_done, .word, .word_valid, .word_ready);
`default_nettype wire

//--- tb/rbs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_host_model
  import rbs_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  input  wire logic      slow,
  input  wire rbs_word_t word,
  input  wire logic      word_valid,
  output logic           word_ready
);
  rbs_word_t  got[$];
  logic [1:0] ph_r;
  // slow mode stalls three cycles out of four so held words get exercised
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 2'h0;
      word_ready <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      word_ready <= !slow || ph_r == 2'h3;
      if (word_valid && word_ready) got.push_back(word);
    end
  end
endmodule
`default_nettype wire

//--- tb/reading_buffer_store_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module reading_buffer_store_tb
  import rbs_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, clear_cmd = 0, autoclear_wr = 0, autoclear_val = 0, slow = 0;
  logic run_start = 0, run_stop = 0, sample_valid = 0, readall_req = 0, range_req = 0, e;
  logic autoclear_q, busy, cmd_error, reply_done, storing, word_valid, word_ready;
  logic [RBS_IDX_W-1:0]  capacity = 12'h064, range_start = 12'h001, range_end = 12'h001;
  logic [RBS_IDX_W-1:0]  stored_count;
  logic [RBS_CHAN_W-1:0] channel = 4'h1;
  logic [RBS_FCNT_W-1:0] field_count = 4'h0;
  rbs_fill_t             fill_mode = fill_once;
  rbs_flist_t            fields = '{default: reading_field};
  rbs_sample_t           sample = '0;
  rbs_rtc_t              rtc = '0;
  rbs_word_t             word;
  int                    error_cnt = 0, num_checks = 0, sn = 0;
  rbs_field_t dflt[4] = '{reading_field, source_field, unit_field, relative_seconds_field};
  rbs_store #(.TICK_CYC(4), .DAY_TICK(20)) u_rbs_store (.sys_clk, .rst_n, .clear_cmd,
    .autoclear_wr, .autoclear_val, .autoclear_q, .fill_mode, .capacity, .run_start, .run_stop,
    .sample_valid, .sample, .rtc, .channel, .readall_req, .range_req, .range_start, .range_end,
    .field_count, .fields, .busy, .cmd_error, .reply_done, .storing, .stored_count, .word,
    .word_valid, .word_ready);
  rbs_host_model u_rbs_host_model (.sys_clk, .rst_n, .slow, .word, .word_valid, .word_ready);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic pulse(input int k, input logic v);
    @(posedge sys_clk);
    autoclear_val <= v;
    case (k)
      0: clear_cmd <= 1'b1;
      1: run_start <= 1'b1;
      2: run_stop <= 1'b1;
      default: autoclear_wr <= 1'b1;
    endcase
    @(posedge sys_clk);
    {clear_cmd, run_start, run_stop, autoclear_wr} <= 4'h0;
    @(negedge sys_clk);
  endtask
  task automatic store();
    sn++;
    @(posedge sys_clk);
    sample <= '{32'h100 + sn, 32'h200 + sn, unit_amps, constant_voltage_state};
    rtc <= '{32'h300 + sn, 32'h400 + sn};
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic query(input logic rng, input int a, input int b, input int nf, output logic er);
    u_rbs_host_model.got.delete();
    @(posedge sys_clk);
    readall_req <= !rng;
    range_req <= rng;
    range_start <= a[11:0];
    range_end <= b[11:0];
    field_count <= nf[3:0];
    @(posedge sys_clk);
    {readall_req, range_req} <= 2'h0;
    er = 1'b0;
    for (int i = 0; i < 4000 && reply_done !== 1'b1 && !er; i++) begin
      @(negedge sys_clk);
      er = (cmd_error === 1'b1);
    end
    `CHK("reply_end", 1'b1, reply_done || er)
  endtask
  function automatic logic [63:0] ed(rbs_field_t f, int s, int idx);
    case (f)
      reading_field: return 64'(32'h100 + s);
      source_field: return 64'(32'h200 + s);
      unit_field: return 64'(unit_amps);
      output_state_field: return 64'(constant_voltage_state);
      date_field: return 64'(32'h300 + s);
      time_field: return 64'(32'h400 + s);
      absolute_stamp_field: return {32'(32'h300 + s), 32'(32'h400 + s)};
      point_index_field: return 64'(idx);
      default: return 64'h0;
    endcase
  endfunction
  // z: first record follows a clear, so its relative time must be zero
  task automatic expect_recs(input int nrec, input int s0, input int i0, input int nf, input logic z);
    int         nfe;
    rbs_field_t f;
    rbs_word_t  w;
    nfe = (nf == 0) ? RBS_DEF_FIELDS : nf;
    `CHK("words", nrec * nfe, u_rbs_host_model.got.size())
    for (int k = 0; k < nrec * nfe && k < u_rbs_host_model.got.size(); k++) begin
      w = u_rbs_host_model.got[k];
      f = (nf == 0) ? dflt[k % nfe] : fields[k % nfe];
      `CHK("field", f, w.field)
      `CHK("index", 12'(i0 + k / nfe), w.index)
      if (f < relative_seconds_field || f == point_index_field || (z && k < nfe))
        `CHK("data", ed(f, s0 + k / nfe, i0 + k / nfe), w.data)
      `CHK("last", k == nrec * nfe - 1, w.last)
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    `CHK("ac_reset", 1'b1, autoclear_q)
    for (int v = 0; v < 2; v++) begin
      pulse(3, v[0]);
      `CHK("ac_q", v[0], autoclear_q)
    end
    pulse(1, 1'b1);
    repeat (3) store();
    `CHK("count3", 12'h003, stored_count)
    @(posedge sys_clk) slow <= 1'b1;
    query(0, 1, 1, 0, e);
    expect_recs(3, 1, 1, 0, 1'b1);
    store();
    query(0, 1, 1, 0, e);
    expect_recs(1, 4, 4, 0, 1'b0);
    @(posedge sys_clk);
    for (int i = 0; i < RBS_MAX_FIELDS; i++) fields[i] <= rbs_field_t'((i * 3) % 10);
    query(1, 1, 2, 10, e);
    expect_recs(2, 1, 1, 10, 1'b1);
    for (int t = 0; t < 3; t++) begin
      @(posedge sys_clk) channel <= (t == 0) ? 4'h2 : 4'h1;
      query(1, (t == 1) ? 0 : 1, 2, (t == 2) ? 11 : 0, e);
      `CHK("cmd_error", 1'b1, e)
    end
    pulse(2, 1'b1);
    pulse(1, 1'b1);
    `CHK("autoclr", 12'h000, stored_count)
    store();
    pulse(3, 1'b0);
    pulse(2, 1'b0);
    pulse(1, 1'b0);
    store();
    `CHK("append", 12'h002, stored_count)
    pulse(0, 1'b0);
    `CHK("clear", 12'h000, stored_count)
    query(0, 1, 1, 0, e);
    expect_recs(0, 0, 1, 0, 1'b0);
    store();
    query(0, 1, 1, 0, e);
    expect_recs(1, 7, 1, 0, 1'b1);
    @(posedge sys_clk) capacity <= 12'h002;
    pulse(0, 1'b0);
    repeat (3) store();
    `CHK("full_count", 12'h002, stored_count)
    `CHK("full_stop", 1'b0, storing)
    repeat (2) begin
      query(0, 1, 1, 0, e);
      expect_recs(2, 8, 1, 0, 1'b1);
    end
    @(posedge sys_clk) fill_mode <= fill_continuous;
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    repeat (3) store();
    `CHK("wrap_count", 12'h002, stored_count)
    query(0, 1, 1, 0, e);
    expect_recs(2, 12, 1, 0, 1'b0);
    @(posedge sys_clk) fill_mode <= fill_never;
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    store();
    `CHK("never", 12'h000, stored_count)
    `CHK("never_run", 1'b0, storing)
    // power cycle while not storing: auto-clear was left off and must come back on
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    `CHK("ac_power", 1'b1, autoclear_q)
    stop_test();
  end
endmodule
`default_nettype wire
